// ---- verilog/timer16_capture.sv ----
`timescale 1ns/1ps
// What this block does
// - Overflow flag on wrap or FFFFH match
// - Overflow clear ignored before count reaches 0001H
// - One-shot only in free or edge-clear mode
// - Capture on fall, interrupt next rise
// - Reverse capture: no interrupt, B edge interrupts
// - High input after reset reads rising once
// - Filter clock mclk or count clock
// - Edge needs two equal consecutive samples
// - Inputs ignored while counter stopped
// - Buffered count copy updated after count-up
// - Mode 00 stops, others count
// - First match may lag one count clock
module timer16_capture
    import timer16_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire ctrl_t ctrl,
    input wire logic timer_input_a,
    input wire logic timer_input_b,
    input wire logic compare_a_write,
    input wire logic [15:0] compare_a_data,
    input wire logic compare_b_write,
    input wire logic [15:0] compare_b_data,
    input wire logic overflow_clear,
    input wire logic oneshot_trigger,
    output status_t status
);

    typedef enum logic [1:0] {OS_IDLE, OS_WAIT, OS_ACTIVE} os_state_t;
    logic [15:0] counter;
    logic [15:0] capcomp_reg_a;
    logic [15:0] capcomp_reg_b;
    logic [15:0] count16_value;
    logic [3:0] pcnt;
    logic started_once;
    logic ovf_recent;
    logic overflow_flag;
    logic pend_a;
    logic pend_b;
    logic irq_channel_a;
    logic irq_channel_b;
    logic tick_d;
    os_state_t os_state;
    os_state_t next_os;
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] samp;
    logic [1:0] lvl;
    logic [1:0] rise_p;
    logic [1:0] fall_p;
    logic [1:0] strobe;
    logic [15:0] next_counter;

    // Mode decode
    wire [1:0] opmode = {ctrl.opmode_bit_hi, ctrl.opmode_bit_lo};
    wire [1:0] edge_sel_a = {ctrl.edge_sel_hi, ctrl.edge_sel_lo};
    wire running = opmode != MODE_STOP;
    wire ext_clock = ctrl.prescaler_mode_reg == PRS_EXT;
    wire track = running | started_once;
    wire [3:0] div_mask = (ctrl.prescaler_mode_reg == PRS_DIV2) ? DIV2_MASK :
                          (ctrl.prescaler_mode_reg == PRS_DIV4) ? DIV4_MASK :
                          DIV16_MASK;
    wire [3:0] half_point = div_mask ^ (div_mask >> 1);

    // Valid and reverse edges; all gated off while stopped
    wire raw_a = (rise_p[0] && (edge_sel_a == EDGE_RISE ||
                  edge_sel_a == EDGE_BOTH)) ||
                 (fall_p[0] && (edge_sel_a == EDGE_FALL ||
                  edge_sel_a == EDGE_BOTH));
    wire edge_a_valid = running && raw_a;
    wire edge_a_rev = running && ((rise_p[0] && edge_sel_a == EDGE_FALL) ||
                      (fall_p[0] && edge_sel_a == EDGE_RISE));
    wire edge_b_valid = running &&
        ((rise_p[1] && (ctrl.edge_sel_b == EDGE_RISE ||
          ctrl.edge_sel_b == EDGE_BOTH)) ||
         (fall_p[1] && (ctrl.edge_sel_b == EDGE_FALL ||
          ctrl.edge_sel_b == EDGE_BOTH)));

    // Count clock phases; prescaler runs free so a start lands anywhere
    // in a count period and the first match may lag one clock
    wire rise_tick = ext_clock ? edge_a_valid :
                     ((pcnt & div_mask) == 4'h0);
    wire fall_tick = ext_clock ? edge_a_valid :
                     ((pcnt & div_mask) == half_point);
    wire tick = running && rise_tick;

    // Capture triggers; input A as count clock gives no B capture
    wire cap_b_ev = edge_a_valid && !ext_clock;
    wire cap_a_ev = ctrl.reverse_capture_select ? edge_a_rev
                                                : edge_b_valid;
    // B edge interrupts channel A in both capture modes
    wire irq_a_ev = edge_b_valid;
    wire irq_b_ev = cap_b_ev;

    wire match_a = counter == capcomp_reg_a;
    wire match_b = counter == capcomp_reg_b;
    wire wrap = tick && counter == COUNT_MAX;
    wire os_allowed = ctrl.oneshot_enable &&
                      (opmode == MODE_FREE || opmode == MODE_CLR_EDGE);
    wire os_trig = oneshot_trigger ||
                   (opmode == MODE_CLR_EDGE && edge_a_valid);
    wire clear_ok = overflow_clear && !ovf_recent;

    // Filter sampling: input A on mclk when it clocks the counter, input B always on the count clock
    assign strobe[0] = ext_clock ? 1'b1 : fall_tick;
    assign strobe[1] = fall_tick;

    // Two-stage sync, then two-sample noise filter per input
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_filter
            wire pin = (gi == 0) ? timer_input_a : timer_input_b;
            wire agree = strobe[gi] && track && (sync[gi] == samp[gi]);
            always_ff @(posedge mclk) begin
                if (!resetn) begin
                    meta[gi] <= 1'b0;
                    sync[gi] <= 1'b0;
                    samp[gi] <= 1'b0;
                    lvl[gi] <= 1'b0;
                    rise_p[gi] <= 1'b0;
                    fall_p[gi] <= 1'b0;
                end else begin
                    meta[gi] <= pin;
                    sync[gi] <= meta[gi];
                    if (strobe[gi] && track) begin
                        samp[gi] <= sync[gi];
                    end
                    // Level moves only on two equal samples
                    if (agree) begin
                        lvl[gi] <= samp[gi];
                    end
                    rise_p[gi] <= agree && samp[gi] && !lvl[gi];
                    fall_p[gi] <= agree && !samp[gi] && lvl[gi];
                end
            end
        end
    endgenerate

    // Next count: stop, edge clear, match clear, or increment
    always_comb begin
        next_counter = counter;
        if (!running) begin
            next_counter = COUNT_ZERO;
        end else if (opmode == MODE_CLR_EDGE && cap_b_ev) begin
            next_counter = COUNT_ZERO;
        end else if (tick && opmode == MODE_CLR_MATCH && match_a) begin
            next_counter = COUNT_ZERO;
        end else if (tick) begin
            next_counter = counter + COUNT_ONE;
        end
    end

    // Counter, overflow and its clear guard
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            counter <= COUNT_ZERO;
            pcnt <= 4'h0;
            started_once <= 1'b0;
            ovf_recent <= 1'b0;
            overflow_flag <= 1'b0;
            tick_d <= 1'b0;
            count16_value <= COUNT_ZERO;
        end else begin
            counter <= next_counter;
            pcnt <= pcnt + 4'h1;
            started_once <= started_once | running;
            ovf_recent <= wrap | (ovf_recent & ~(tick | ~running));
            // Set wins over a clear in the same cycle
            overflow_flag <= wrap || (overflow_flag && !clear_ok);
            tick_d <= tick;
            // Copy lags the count-up, so a read may see the old value
            if (tick_d || !running) begin
                count16_value <= counter;
            end
        end
    end
    // Capture registers double as compare registers
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            capcomp_reg_a <= COUNT_ZERO;
            capcomp_reg_b <= COUNT_ZERO;
        end else begin
            if (cap_a_ev) begin
                capcomp_reg_a <= counter;
            end else if (compare_a_write) begin
                capcomp_reg_a <= compare_a_data;
            end
            if (cap_b_ev) begin
                capcomp_reg_b <= counter;
            end else if (compare_b_write) begin
                capcomp_reg_b <= compare_b_data;
            end
        end
    end

    // Interrupts wait for the next rising count clock edge
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pend_a <= 1'b0;
            pend_b <= 1'b0;
            irq_channel_a <= 1'b0;
            irq_channel_b <= 1'b0;
        end else begin
            pend_a <= irq_a_ev ? 1'b1 : (rise_tick ? 1'b0 : pend_a);
            pend_b <= irq_b_ev ? 1'b1 : (rise_tick ? 1'b0 : pend_b);
            irq_channel_a <= pend_a && rise_tick;
            irq_channel_b <= pend_b && rise_tick;
        end
    end

    // One-shot: trigger arms, B match starts, A match ends the pulse
    always_comb begin
        next_os = os_state;
        case (os_state)
            OS_IDLE: begin
                // Triggers while busy are dropped
                if (os_trig) begin
                    next_os = OS_WAIT;
                end
            end
            OS_WAIT: begin
                if (tick && match_b) begin
                    next_os = OS_ACTIVE;
                end
            end
            OS_ACTIVE: begin
                if (tick && match_a) begin
                    next_os = OS_IDLE;
                end
            end
            default: begin
                next_os = OS_IDLE;
            end
        endcase
        if (!os_allowed) begin
            next_os = OS_IDLE;
        end
    end
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            os_state <= OS_IDLE;
        end else begin
            os_state <= next_os;
        end
    end
    assign status = '{count16_value: count16_value,
                      capcomp_reg_a: capcomp_reg_a,
                      capcomp_reg_b: capcomp_reg_b,
                      overflow_flag: overflow_flag,
                      irq_channel_a: irq_channel_a,
                      irq_channel_b: irq_channel_b,
                      oneshot_out: os_state == OS_ACTIVE};
    // Checks share the one clock and its reset
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    sequence s_capture_b;
        cap_b_ev && !ext_clock;
    endsequence
    a_ovf_on_wrap: assert property (wrap |=> overflow_flag)
        else $error("overflow flag not set on wrap");
    a_ovf_clear_blocked: assert property (
        overflow_flag && ovf_recent && !tick |=> overflow_flag)
        else $error("overflow clear took effect too early");
    a_oneshot_mode_gate: assert property (
        opmode == MODE_CLR_MATCH |=> !status.oneshot_out)
        else $error("one-shot active in match-clear mode");
    a_capture_value_b: assert property (
        s_capture_b |=> capcomp_reg_b == $past(counter))
        else $error("capture value wrong");
    a_capture_irq_b: assert property (
        s_capture_b ##1 !irq_channel_b |-> ##[0:17] irq_channel_b)
        else $error("capture interrupt missing");
    a_rev_no_irq: assert property (
        cap_a_ev && ctrl.reverse_capture_select && !edge_b_valid &&
        !pend_a |=> !pend_a)
        else $error("reverse capture raised an interrupt");
    a_stopped_ignore: assert property (
        !running |-> !cap_a_ev && !cap_b_ev && !irq_a_ev)
        else $error("input acted while stopped");
    a_buffer_follows: assert property (
        tick |=> ##1 count16_value == $past(counter))
        else $error("count buffer not updated");
    a_stop_zero: assert property (!running |=> counter == '0)
        else $error("counter not cleared when stopped");
    a_filter_two: assert property (
        rise_p[1] |-> $past(samp[1]) && $past(sync[1]))
        else $error("edge without two samples");
endmodule : timer16_capture

// ---- pkg/timer16_pkg.sv ----
package timer16_pkg;

    // Operating mode field
    localparam logic [1:0] MODE_STOP = 2'h0;
    localparam logic [1:0] MODE_CLR_EDGE = 2'h1;
    localparam logic [1:0] MODE_FREE = 2'h2;
    localparam logic [1:0] MODE_CLR_MATCH = 2'h3;

    // Valid edge selection
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // Count clock selection and divider masks
    localparam logic [1:0] PRS_DIV2 = 2'h0;
    localparam logic [1:0] PRS_DIV4 = 2'h1;
    localparam logic [1:0] PRS_DIV16 = 2'h2;
    localparam logic [1:0] PRS_EXT = 2'h3;
    localparam logic [3:0] DIV2_MASK = 4'h1;
    localparam logic [3:0] DIV4_MASK = 4'h3;
    localparam logic [3:0] DIV16_MASK = 4'hF;

    // Counter values
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

    typedef struct packed {
        logic opmode_bit_hi;
        logic opmode_bit_lo;
        logic edge_sel_hi;
        logic edge_sel_lo;
        logic [1:0] edge_sel_b;
        logic [1:0] prescaler_mode_reg;
        logic reverse_capture_select;
        logic oneshot_enable;
    } ctrl_t;

    typedef struct packed {
        logic [15:0] count16_value;
        logic [15:0] capcomp_reg_a;
        logic [15:0] capcomp_reg_b;
        logic overflow_flag;
        logic irq_channel_a;
        logic irq_channel_b;
        logic oneshot_out;
    } status_t;

endpackage : timer16_pkg

// ---- dv/pulse_source.sv ----
`timescale 1ns/1ps
// Far-side pulse source on the two timer input pins
module pulse_source (
    input wire logic mclk,
    output logic pin_a,
    output logic pin_b
);
    // Pins idle low until the bench asks otherwise
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end

    // Called just after a falling edge; holds the level for whole cycles
    // so a pulse is never shorter than the width the caller chose
    task automatic drive(input bit sel, input bit lvl, input int cyc);
        if (sel)
            pin_b = lvl;
        else
            pin_a = lvl;
        repeat (cyc) @(negedge mclk);
    endtask : drive
endmodule : pulse_source

// ---- dv/timer16_capture_edge_overflow_tb.sv ----
`timescale 1ns/1ps
module timer16_capture_edge_overflow_tb;
    import timer16_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    ctrl_t ctrl = '0;
    logic wr_a = 1'b0;
    logic wr_b = 1'b0;
    logic os_trig = 1'b0;
    logic ovf_clr = 1'b0;
    logic [15:0] wd_a = 16'h0000;
    logic [15:0] wd_b = 16'h0000;
    status_t st;
    logic pin_a;
    logic pin_b;
    logic [15:0] prev;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    int na = 0;
    int nb = 0;
    int os_hi = 0;
    int ea;
    int base;
    int w;
    int p;
    int q[$];

    // Free-running clock, 8 ns period
    always #4 mclk = ~mclk;

    timer16_capture DUT (.mclk(mclk), .resetn(resetn), .ctrl(ctrl),
        .timer_input_a(pin_a), .timer_input_b(pin_b),
        .compare_a_write(wr_a), .compare_a_data(wd_a),
        .compare_b_write(wr_b), .compare_b_data(wd_b),
        .overflow_clear(ovf_clr), .oneshot_trigger(os_trig), .status(st));

    pulse_source src (.mclk(mclk), .pin_a(pin_a), .pin_b(pin_b));

    // Tally pulses and levels; the ceiling cuts a hang short
    always @(posedge mclk) begin
        cyc++;
        na += (st.irq_channel_a === 1'b1);
        nb += (st.irq_channel_b === 1'b1);
        os_hi += (st.oneshot_out === 1'b1);
        if (cyc == 6000) begin
            fails++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    // Edge selection only moves while the counter is stopped
    task automatic setup(input logic [1:0] e_a, e_b, m, input logic rev);
        {ctrl.opmode_bit_hi, ctrl.opmode_bit_lo} = MODE_STOP;
        @(negedge mclk);
        {ctrl.edge_sel_hi, ctrl.edge_sel_lo} = e_a;
        ctrl.edge_sel_b = e_b;
        ctrl.reverse_capture_select = rev;
        @(negedge mclk);
        {ctrl.opmode_bit_hi, ctrl.opmode_bit_lo} = m;
        @(negedge mclk);
    endtask : setup

    // Compares loaded while stopped; active level spans B to A match
    task automatic one_shot(input logic [1:0] m, input int exp);
        setup(2'h2, 2'h2, MODE_STOP, 1'b0);
        wd_a = 16'h0014;
        wd_b = 16'h000A;
        wr_a = 1'b1;
        wr_b = 1'b1;
        @(negedge mclk);
        wr_a = 1'b0;
        wr_b = 1'b0;
        {ctrl.opmode_bit_hi, ctrl.opmode_bit_lo} = m;
        @(negedge mclk);
        os_hi = 0;
        os_trig = 1'b1;
        @(negedge mclk);
        os_trig = 1'b0;
        repeat (120) @(negedge mclk);
        check("oneshot_len", 16'(os_hi), 16'(exp));
    endtask : one_shot

    initial begin
        p = $urandom(97);
        ctrl.oneshot_enable = 1'b1;
        ctrl.prescaler_mode_reg = PRS_DIV2;
        @(negedge mclk);
        src.drive(1'b0, 1'b1, 7);
        check("count", st.count16_value, COUNT_ZERO);
        check("ovf", 16'(st.overflow_flag), 16'h0000);
        check("cap_a", st.capcomp_reg_a, COUNT_ZERO);
        resetn = 1'b1;
        // A clear with no overflow pending must leave the flag low
        ovf_clr = 1'b1;
        @(negedge mclk);
        ovf_clr = 1'b0;
        check("ovf_clr", 16'(st.overflow_flag), 16'h0000);
        $display("test reset done");
        // Pin A high since reset: only the first start sees an edge
        setup(EDGE_RISE, 2'h2, MODE_FREE, 1'b0);
        repeat (40) @(negedge mclk);
        check("first_rise", 16'(nb), 16'h0001);
        setup(EDGE_RISE, 2'h2, MODE_FREE, 1'b0);
        repeat (40) @(negedge mclk);
        check("restart", 16'(nb), 16'h0001);
        prev = st.count16_value;
        repeat (64) @(negedge mclk);
        check("advance", st.count16_value - prev, 16'h0020);
        $display("test start done");
        // Pin activity while stopped must leave no trace
        setup(EDGE_BOTH, EDGE_BOTH, MODE_STOP, 1'b0);
        base = na + nb;
        src.drive(1'b0, 1'b0, 12);
        src.drive(1'b1, 1'b1, 12);
        src.drive(1'b1, 1'b0, 12);
        check("stop_irq", 16'(na + nb - base), 16'h0000);
        check("stop_cnt", st.count16_value, COUNT_ZERO);
        $display("test stopped done");
        // Random B spacing; captures step by half the spacing
        setup(2'h2, EDGE_RISE, MODE_FREE, 1'b0);
        ea = na;
        base = nb;
        repeat (20) @(negedge mclk);
        for (int k = 0; k < 5; k++) begin
            p = 16 * $urandom_range(5, 12);
            w = 5 + $urandom_range(0, 10);
            src.drive(1'b1, 1'b1, w);
            src.drive(1'b1, 1'b0, p - w);
            ea++;
            if (k > 0)
                check("cap_step", st.capcomp_reg_a - prev,
                      16'(q.pop_front()));
            prev = st.capcomp_reg_a;
            q.push_back(p / 2);
        end
        check("irq_a", 16'(na), 16'(ea));
        check("irq_b", 16'(nb), 16'(base));
        $display("test capture done");
        // Reverse phase: B interrupts only, A falling captures silently
        setup(EDGE_RISE, EDGE_RISE, MODE_FREE, 1'b1);
        src.drive(1'b1, 1'b0, 40);
        prev = st.capcomp_reg_a;
        ea = na + 1;
        src.drive(1'b1, 1'b1, 10);
        src.drive(1'b1, 1'b0, 40);
        check("rev_b_irq", 16'(na), 16'(ea));
        check("rev_b_cap", st.capcomp_reg_a, prev);
        w = st.capcomp_reg_b;
        base = nb;
        src.drive(1'b0, 1'b1, 10);
        src.drive(1'b0, 1'b0, 40);
        check("rev_a_irq", 16'(na), 16'(ea));
        check("rev_a_cap", 16'(st.capcomp_reg_a != prev), 16'h1);
        check("irq_b_a", 16'(nb), 16'(base + 1));
        check("cap_b", 16'(st.capcomp_reg_b != 16'(w)), 16'h1);
        $display("test reverse done");
        one_shot(MODE_FREE, 20);
        one_shot(MODE_CLR_EDGE, 20);
        one_shot(MODE_CLR_MATCH, 0);
        $display("test oneshot done");
        test_done();
    end
endmodule : timer16_capture_edge_overflow_tb
